//--- common/dcp_consts.svh
// constants for the disk command parameter engine
// Behaviour
// - Low perpendicular bits change only while the unlock flag is 1.
// - The unlock flag guards bits 3..0 of the perpendicular byte.
// - Sense interrupt status returns the tracked present cylinder.
// - Poll disable set stops the polling routine, clear lets it run.
// - Precompensation starts at a track anywhere from 00 to FFH.
// - Multi-sector transfers start at the given first sector.
// - Relative seek adds or subtracts the offset from the cylinder.
// - Format initialises exactly sectors_per_track sectors.
// - Verify with count enable checks sectors_per_track sectors.
// - Bypass 1 in read data skips sectors marked deleted.
// - Bypass 1 in read deleted accesses only deleted sectors.
// - Bypass 0 accesses every sector whatever its mark.
// - Step pulses are spaced 0.5 to 8 ms in 0.5 ms units at 1 Mbit.
// - Four status registers hold results readable after a command.
// - Write gate timing gives writes a pre-erase period before data.
`ifndef DCP_CONSTS_SVH
`define DCP_CONSTS_SVH
`define DCP_A_CTRL    4'h0
`define DCP_A_PERP    4'h1
`define DCP_A_PRECOMP_START_TRACK  4'h2
`define DCP_A_STEP    4'h3
`define DCP_A_FIRST   4'h4
`define DCP_A_SPT     4'h5
`define DCP_A_RCN     4'h6
`define DCP_A_CMD     4'h7
`define DCP_A_ST0     4'h8
`define DCP_A_ST1     4'h9
`define DCP_A_ST2     4'hA
`define DCP_A_ST3     4'hB
`define DCP_A_PCN     4'hC
`define DCP_A_ISTAT   4'hD
`define DCP_A_IMASK   4'hE
`define DCP_A_CURSEC  4'hF
`define DCP_B_POLLDIS 0
`define DCP_B_BYPASS  1
`define DCP_B_EC      2
`define DCP_B_WRITE_GATE_TIMING   3
`define DCP_B_UNLOCK  4
`define DCP_B_DIRDN   7
`define DCP_B_SE      5
`define DCP_B_T0      4
`define DCP_B_CM      6
`define DCP_I_DONE    0
`define DCP_I_SKIP    1
`define DCP_RST_BYTE  8'h00
`define DCP_CLK_NS       40
`define DCP_STEP_UNIT_NS 500000
`define DCP_PREERASE_NS  320
`define DCP_PREERASE_CYC ((`DCP_PREERASE_NS + `DCP_CLK_NS - 1) / `DCP_CLK_NS)
`define DCP_STEP_UNIT_CYC (`DCP_STEP_UNIT_NS / `DCP_CLK_NS)
`endif

//--- common/dcp_pkg.sv
// types of the disk command parameter engine
package dcp_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_STEP = 2'b01,
		ST_SECT = 2'b10,
		ST_DONE = 2'b11
	} dcp_state_type;
	typedef enum logic [2:0] {
		OP_NONE    = 3'b000,
		OP_RSEEK   = 3'b001,
		OP_FORMAT  = 3'b010,
		OP_VERIFY  = 3'b011,
		OP_READ    = 3'b100,
		OP_READDEL = 3'b101,
		OP_WRITE   = 3'b110,
		OP_SENSE   = 3'b111
	} dcp_op_type;
	typedef struct packed {
		dcp_state_type st;
		dcp_op_type    op;
		logic [7:0]    ctrl;
		logic [7:0]    perp;
		logic [7:0]    precomp_start_track;
		logic [7:0]    stepc;
		logic [7:0]    first;
		logic [7:0]    spt;
		logic [7:0]    relative_cylinder_offset;
		logic [7:0]    present_cylinder;
		logic [7:0]    target;
		logic [7:0]    cur_sec;
		logic [7:0]    count;
		logic [7:0]    st0;
		logic [7:0]    st1;
		logic [7:0]    st2;
		logic [7:0]    st3;
		logic [7:0]    sensed;
		logic [7:0]    irq;
		logic [7:0]    mask;
		logic [7:0]    rdata;
		logic [13:0]   unit_cnt;
		logic [6:0]    step_cnt;
		logic [3:0]    pre_cnt;
		logic [2:0]    sp_sync;
		logic [2:0]    dm_sync;
		logic          sp_f;
		logic          dm_f;
		logic          step;
		logic          dir;
		logic          we;
		logic          precomp;
		logic          access;
		logic          poll;
		logic          irq_out;
	} dcp_regs_type;
endpackage

//--- rtl/dcp_engine.sv
// disk command parameter engine with register port and drive signals
`timescale 1ns/1ps
`default_nettype none
`include "dcp_consts.svh"
module dcp_engine #(
	parameter logic [13:0] STEP_UNIT_CYC = 14'(`DCP_STEP_UNIT_CYC)
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic [7:0]      rdata,
	input  wire logic       sector_pulse_pin,
	input  wire logic       deleted_mark_pin,
	output logic            step_pulse,
	output logic            step_dir,
	output logic            write_enable,
	output logic            precomp_enable,
	output logic            poll_active,
	output logic            sector_access,
	output logic            irq
);
	localparam logic [3:0] PRE_CYC = 4'(`DCP_PREERASE_CYC);

	dcp_pkg::dcp_regs_type q;
	dcp_pkg::dcp_regs_type d;
	logic       start;
	logic       sec_edge;
	logic       skip;
	logic       count_mode;
	logic [7:0] set;
	logic [7:0] tgt;
	logic [4:0] base;
	logic [2:0] mult;
	logic [6:0] units;

	always_comb begin
		d = q;
		set = 8'h00;
		tgt = q.present_cylinder;
		skip = 1'b0;
		d.step = 1'b0;
		d.access = 1'b0;
		start = wr && addr == `DCP_A_CMD && q.st == dcp_pkg::ST_IDLE;
		// first stage feeds only the second; filter on stages two and three
		d.sp_sync = {q.sp_sync[1:0], sector_pulse_pin};
		d.dm_sync = {q.dm_sync[1:0], deleted_mark_pin};
		if (q.sp_sync[1] == q.sp_sync[2]) begin
			d.sp_f = q.sp_sync[2];
		end
		if (q.dm_sync[1] == q.dm_sync[2]) begin
			d.dm_f = q.dm_sync[2];
		end
		sec_edge = d.sp_f & ~q.sp_f;

		// 16 - code gives 16 down to 1 half-ms units
		base = 5'h10 - {1'b0, q.stepc[3:0]};
		case (q.stepc[5:4])
			2'h0: mult = 3'h1;
			2'h1: mult = 3'h2;
			// 300 kbit would be x3.33; x3 keeps the multiplier integer
			2'h2: mult = 3'h3;
			default: mult = 3'h4;
		endcase
		units = 7'(base * mult);

		if (wr) begin
			case (addr)
				`DCP_A_CTRL: d.ctrl = wdata;
				`DCP_A_PERP: begin
					d.perp[7:4] = wdata[7:4];
					if (q.ctrl[`DCP_B_UNLOCK]) begin
						d.perp[3:0] = wdata[3:0];
					end
				end
				`DCP_A_PRECOMP_START_TRACK: d.precomp_start_track = wdata;
				`DCP_A_STEP: d.stepc = wdata;
				`DCP_A_FIRST: d.first = wdata;
				`DCP_A_SPT: d.spt = wdata;
				`DCP_A_RCN: d.relative_cylinder_offset = wdata;
				`DCP_A_IMASK: d.mask = wdata;
				default: d.mask = q.mask;
			endcase
		end

		if (q.ctrl[`DCP_B_DIRDN]) begin
			tgt = (q.present_cylinder < q.relative_cylinder_offset) ? 8'h00 : q.present_cylinder - q.relative_cylinder_offset;
		end else begin
			tgt = (8'hFF - q.present_cylinder < q.relative_cylinder_offset) ? 8'hFF : q.present_cylinder + q.relative_cylinder_offset;
		end
		count_mode = q.op == dcp_pkg::OP_FORMAT ||
			(q.op == dcp_pkg::OP_VERIFY && q.ctrl[`DCP_B_EC]);

		case (q.st)
			dcp_pkg::ST_IDLE: begin
				if (start) begin
					d.op = dcp_pkg::dcp_op_type'(wdata[2:0]);
					case (dcp_pkg::dcp_op_type'(wdata[2:0]))
						dcp_pkg::OP_NONE: d.st = dcp_pkg::ST_IDLE;
						dcp_pkg::OP_RSEEK: begin
							d.target = tgt;
							d.step_cnt = units;
							d.unit_cnt = 14'h0000;
							d.dir = tgt < q.present_cylinder;
							d.st = (tgt == q.present_cylinder) ? dcp_pkg::ST_DONE
								: dcp_pkg::ST_STEP;
						end
						dcp_pkg::OP_SENSE: begin
							d.sensed = q.present_cylinder;
							d.st = dcp_pkg::ST_DONE;
						end
						default: begin
							d.st2 = 8'h00;
							d.cur_sec = q.first;
							d.count = 8'h00;
							d.we = wdata[2:0] == 3'(dcp_pkg::OP_WRITE) ||
								wdata[2:0] == 3'(dcp_pkg::OP_FORMAT);
							// perpendicular drives need erase ahead of data
							d.pre_cnt = (d.we && q.ctrl[`DCP_B_WRITE_GATE_TIMING])
								? PRE_CYC : 4'h0;
							d.st = dcp_pkg::ST_SECT;
						end
					endcase
				end
			end
			dcp_pkg::ST_STEP: begin
				if (q.unit_cnt == STEP_UNIT_CYC - 14'h0001) begin
					d.unit_cnt = 14'h0000;
					if (q.step_cnt == 7'h01) begin
						d.step = 1'b1;
						d.present_cylinder = q.dir ? q.present_cylinder - 8'h01 : q.present_cylinder + 8'h01;
						d.step_cnt = units;
						if (d.present_cylinder == q.target) begin
							d.st = dcp_pkg::ST_DONE;
						end
					end else begin
						d.step_cnt = q.step_cnt - 7'h01;
					end
				end else begin
					d.unit_cnt = q.unit_cnt + 14'h0001;
				end
			end
			dcp_pkg::ST_SECT: begin
				if (q.pre_cnt != 4'h0) begin
					d.pre_cnt = q.pre_cnt - 4'h1;
				end else if (sec_edge) begin
					skip = q.ctrl[`DCP_B_BYPASS] &&
						((q.op == dcp_pkg::OP_READ && q.dm_f) ||
						(q.op == dcp_pkg::OP_READDEL && !q.dm_f));
					if (skip) begin
						d.st2[`DCP_B_CM] = 1'b1;
						set[`DCP_I_SKIP] = 1'b1;
					end else begin
						d.access = 1'b1;
						d.count = q.count + 8'h01;
					end
					// a bypassed sector still uses up its number
					d.cur_sec = q.cur_sec + 8'h01;
					if (count_mode ? d.count == q.spt
						: q.cur_sec == q.spt) begin
						// host reads back the last sector reached
						d.cur_sec = q.cur_sec;
						d.st = dcp_pkg::ST_DONE;
					end
				end
			end
			dcp_pkg::ST_DONE: begin
				d.we = 1'b0;
				if (q.op != dcp_pkg::OP_SENSE) begin
					d.st0 = 8'h00;
					d.st0[`DCP_B_SE] = q.op == dcp_pkg::OP_RSEEK;
					d.st1 = 8'h00;
				end
				d.st3 = 8'h00;
				d.st3[`DCP_B_T0] = q.present_cylinder == 8'h00;
				set[`DCP_I_DONE] = 1'b1;
				d.st = dcp_pkg::ST_IDLE;
			end
			default: d.st = dcp_pkg::ST_IDLE;
		endcase

		d.rdata = 8'h00;
		if (rd) begin
			case (addr)
				`DCP_A_CTRL: d.rdata = q.ctrl;
				`DCP_A_PERP: d.rdata = q.perp;
				`DCP_A_PRECOMP_START_TRACK: d.rdata = q.precomp_start_track;
				`DCP_A_STEP: d.rdata = q.stepc;
				`DCP_A_FIRST: d.rdata = q.first;
				`DCP_A_SPT: d.rdata = q.spt;
				`DCP_A_RCN: d.rdata = q.relative_cylinder_offset;
				`DCP_A_CMD: d.rdata = {3'h0, q.st, q.op};
				`DCP_A_ST0: d.rdata = q.st0;
				`DCP_A_ST1: d.rdata = q.st1;
				`DCP_A_ST2: d.rdata = q.st2;
				`DCP_A_ST3: d.rdata = q.st3;
				`DCP_A_PCN: d.rdata = q.sensed;
				`DCP_A_ISTAT: d.rdata = q.irq;
				`DCP_A_IMASK: d.rdata = q.mask;
				default: d.rdata = q.cur_sec;
			endcase
		end
		// a new event in the clearing read survives
		d.irq = ((rd && addr == `DCP_A_ISTAT) ? 8'h00 : q.irq) | set;
		d.irq_out = |(d.irq & d.mask);
		d.poll = !d.ctrl[`DCP_B_POLLDIS];
		d.precomp = d.we && d.present_cylinder >= d.precomp_start_track;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rdata = q.rdata;
	assign step_pulse = q.step;
	assign step_dir = q.dir;
	assign write_enable = q.we;
	assign precomp_enable = q.precomp;
	assign poll_active = q.poll;
	assign sector_access = q.access;
	assign irq = q.irq_out;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	a_perp_locked: assert property (
		wr && addr == `DCP_A_PERP && !q.ctrl[`DCP_B_UNLOCK]
		|=> q.perp[3:0] == $past(q.perp[3:0]))
		else $error("locked perpendicular bits changed");
	a_perp_open: assert property (
		wr && addr == `DCP_A_PERP && q.ctrl[`DCP_B_UNLOCK]
		|=> q.perp == $past(wdata))
		else $error("unlocked perpendicular byte not taken");
	a_sense_pcn: assert property (
		start && wdata[2:0] == 3'(dcp_pkg::OP_SENSE)
		|=> q.sensed == $past(q.present_cylinder) ##1 q.irq[`DCP_I_DONE])
		else $error("sense result lacks present cylinder");
	a_poll_follow: assert property (
		wr && addr == `DCP_A_CTRL |=> poll_active == !$past(wdata[0]))
		else $error("poll state does not follow disable bit");
	a_precomp_track: assert property (
		precomp_enable |-> write_enable && q.present_cylinder >= q.precomp_start_track)
		else $error("precompensation below start track");
	a_first_sector: assert property (
		start && wdata[2:0] == 3'(dcp_pkg::OP_READ)
		|=> q.cur_sec == $past(q.first) && q.count == 8'h00)
		else $error("transfer did not start at first sector");
	a_step_move: assert property (
		step_pulse |-> q.present_cylinder == ($past(q.dir) ? $past(q.present_cylinder) - 8'h01
			: $past(q.present_cylinder) + 8'h01))
		else $error("step did not move cylinder by one");
	a_step_gap: assert property (
		step_pulse |=> !step_pulse [*2])
		else $error("step pulses too close");
	a_read_bypass: assert property (
		sector_access && q.op == dcp_pkg::OP_READ && q.ctrl[`DCP_B_BYPASS]
		|-> !$past(q.dm_f))
		else $error("deleted sector accessed in read");
	a_del_only: assert property (
		sector_access && q.op == dcp_pkg::OP_READDEL &&
		q.ctrl[`DCP_B_BYPASS] |-> $past(q.dm_f))
		else $error("normal sector accessed in read deleted");
	a_no_skip: assert property (
		q.st == dcp_pkg::ST_SECT && q.pre_cnt == 4'h0 && sec_edge &&
		!q.ctrl[`DCP_B_BYPASS] |=> sector_access)
		else $error("sector skipped without bypass");
	a_format_count: assert property (
		q.st == dcp_pkg::ST_DONE && q.op == dcp_pkg::OP_FORMAT
		|-> q.count == q.spt)
		else $error("format count differs from sectors per track");
	a_preerase_wait: assert property (
		q.st == dcp_pkg::ST_SECT && q.pre_cnt != 4'h0 |=> !sector_access)
		else $error("sector accessed during pre-erase");
	a_verify_count: assert property (
		q.st == dcp_pkg::ST_DONE && q.op == dcp_pkg::OP_VERIFY &&
		q.ctrl[`DCP_B_EC] |-> q.count == q.spt)
		else $error("verify count differs from sectors per track");
	a_seek_status: assert property (
		q.st == dcp_pkg::ST_DONE && q.op == dcp_pkg::OP_RSEEK
		|=> q.st0[`DCP_B_SE] && q.irq[`DCP_I_DONE])
		else $error("seek end not reported in status");
	a_skip_flag: assert property (
		skip |=> q.st2[`DCP_B_CM] && q.irq[`DCP_I_SKIP])
		else $error("bypassed sector not flagged");
	a_seek_target: assert property (
		step_pulse && q.present_cylinder == q.target |-> q.st == dcp_pkg::ST_DONE)
		else $error("seek did not stop at target");
	a_rdata_idle: assert property (
		!rd |=> rdata == 8'h00)
		else $error("read data left standing");

	c_seek_done: cover property (
		step_pulse ##[1:1000] q.st == dcp_pkg::ST_DONE);
	c_skip_seen: cover property (q.st2[`DCP_B_CM]);
	c_format_end: cover property (
		q.st == dcp_pkg::ST_DONE && q.op == dcp_pkg::OP_FORMAT);
	c_irq_high: cover property (irq);
	c_preerase: cover property (q.st == dcp_pkg::ST_SECT && q.pre_cnt == 4'h1);
endmodule
`default_nettype wire

//--- test/dcp_drive_model.sv
// drive model: sector pulses and deleted marks while spinning
`timescale 1ns/1ps
`default_nettype none
module dcp_drive_model (
	input  wire logic       ref_clk,
	input  wire logic       spin,
	input  wire logic [7:0] del_mask,
	output logic            sector_pulse_pin,
	output logic            deleted_mark_pin
);
	logic [3:0] ph  = 4'h0;
	logic [2:0] idx = 3'h0;
	logic       tog = 1'b0;
	always @(posedge ref_clk) begin
		tog <= ~tog;
		if (!spin) begin
			ph  <= 4'h0;
			idx <= 3'h0;
		end else begin
			ph <= ph + 4'h1;
			if (ph == 4'hF) begin
				idx <= idx + 3'h1;
			end
		end
	end
	// early pulse lands inside any pre-erase window
	assign sector_pulse_pin = spin && (ph == 4'h2 || ph == 4'h3);
	// mark line is meaningless off the disk, so keep it moving
	assign deleted_mark_pin = spin ? del_mask[idx] : tog;
endmodule
`default_nettype wire

//--- test/tb_dcp_engine.sv
// register-level testbench of the disk command parameter engine
`timescale 1ns/1ps
`default_nettype none
`include "dcp_consts.svh"
module tb_dcp_engine;
	logic       ref_clk = 1'b0;
	logic       rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] rdata;
	logic       sp_pin, dm_pin, step_pulse, step_dir, write_enable;
	logic       precomp_enable, poll_active, sector_access, irq;
	logic       spin = 1'b0;
	logic [7:0] del_mask = 8'h00;
	int         miscompares = 0;
	int         n_checks = 0;
	int         cyc = 0, n_step = 0, n_acc = 0, last_t = 0, gap = 0;
	int         we_t = 0, acc_t = 0;
	logic       last_dir = 1'b0, last_pc = 1'b0, we_prev = 1'b0;

	always #20 ref_clk = ~ref_clk;

	dcp_engine #(.STEP_UNIT_CYC(14'h0004)) u_dut (
		.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .sector_pulse_pin(sp_pin),
		.deleted_mark_pin(dm_pin), .step_pulse(step_pulse),
		.step_dir(step_dir), .write_enable(write_enable),
		.precomp_enable(precomp_enable), .poll_active(poll_active),
		.sector_access(sector_access), .irq(irq));

	dcp_drive_model u_drive (
		.ref_clk(ref_clk), .spin(spin), .del_mask(del_mask),
		.sector_pulse_pin(sp_pin), .deleted_mark_pin(dm_pin));

	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (step_pulse === 1'b1) begin
			gap = cyc - last_t;
			last_t = cyc;
			last_dir = step_dir;
			n_step = n_step + 1;
		end
		if (sector_access === 1'b1) begin
			if (n_acc == 0) begin
				acc_t = cyc;
			end
			last_pc = precomp_enable;
			n_acc = n_acc + 1;
		end
		if (write_enable === 1'b1 && we_prev !== 1'b1) begin
			we_t = cyc;
		end
		we_prev = write_enable;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask

	task automatic wait_done(input logic [7:0] exp_istat);
		int i;
		for (i = 0; i < 3000 && irq !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (irq !== 1'b1) begin
			miscompares++;
			summarize();
		end
		rreg(`DCP_A_ISTAT, exp_istat);
	endtask

	task automatic cmd(input logic [7:0] op);
		n_step = 0;
		n_acc = 0;
		wreg(`DCP_A_CMD, op);
	endtask

	task automatic seek(input logic [7:0] ctl, input logic [7:0] stp,
		input logic [7:0] off, input logic [7:0] present_cylinder);
		wreg(`DCP_A_CTRL, ctl);
		wreg(`DCP_A_STEP, stp);
		wreg(`DCP_A_RCN, off);
		cmd(8'h01);
		wait_done(8'h01);
		check(8'(n_step), off);
		check({7'h00, last_dir}, {7'h00, ctl[7]});
		rreg(`DCP_A_ST0, 8'h20);
		cmd(8'h07);
		wait_done(8'h01);
		rreg(`DCP_A_PCN, present_cylinder);
	endtask

	task automatic sect(input logic [7:0] op, input logic [7:0] ctl,
		input logic [7:0] first, input logic [7:0] spt,
		input logic [7:0] mask, input logic [7:0] n_exp,
		input logic [7:0] ist);
		wreg(`DCP_A_CTRL, ctl);
		wreg(`DCP_A_FIRST, first);
		wreg(`DCP_A_SPT, spt);
		del_mask <= mask;
		cmd(op);
		spin <= 1'b1;
		wait_done(ist);
		spin <= 1'b0;
		check(8'(n_acc), n_exp);
	endtask

	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		check({7'h00, poll_active}, 8'h01);
		rreg(`DCP_A_CTRL, 8'h00);
		wreg(`DCP_A_IMASK, 8'h01);
		wreg(`DCP_A_PERP, 8'hFF);
		rreg(`DCP_A_PERP, 8'hF0);
		wreg(`DCP_A_CTRL, 8'h10);
		wreg(`DCP_A_PERP, 8'h0A);
		rreg(`DCP_A_PERP, 8'h0A);
		wreg(`DCP_A_CTRL, 8'h00);
		wreg(`DCP_A_PERP, 8'h05);
		rreg(`DCP_A_PERP, 8'h0A);
		wreg(`DCP_A_CTRL, 8'h01);
		#1;
		check({7'h00, poll_active}, 8'h00);
		wreg(`DCP_A_CTRL, 8'h00);
		#1;
		check({7'h00, poll_active}, 8'h01);
		wreg(`DCP_A_PRECOMP_START_TRACK, 8'hFF);
		rreg(`DCP_A_PRECOMP_START_TRACK, 8'hFF);
		// one unit at full rate is four cycles in this build
		seek(8'h00, 8'h0F, 8'h03, 8'h03);
		check(8'(gap), 8'h04);
		// two units doubled at the half rate
		seek(8'h80, 8'h1E, 8'h02, 8'h01);
		check(8'(gap), 8'h10);
		sect(8'h02, 8'h00, 8'h01, 8'h03, 8'h00, 8'h03, 8'h01);
		sect(8'h03, 8'h04, 8'h01, 8'h02, 8'h00, 8'h02, 8'h01);
		sect(8'h04, 8'h00, 8'h02, 8'h04, 8'h00, 8'h03, 8'h01);
		rreg(`DCP_A_CURSEC, 8'h04);
		sect(8'h04, 8'h02, 8'h01, 8'h03, 8'h02, 8'h02, 8'h03);
		rreg(`DCP_A_ST2, 8'h40);
		sect(8'h04, 8'h00, 8'h01, 8'h03, 8'h02, 8'h03, 8'h01);
		rreg(`DCP_A_ST2, 8'h00);
		sect(8'h05, 8'h02, 8'h01, 8'h03, 8'h06, 8'h02, 8'h03);
		// the early pulse falls in pre-erase and is not counted
		sect(8'h06, 8'h08, 8'h01, 8'h02, 8'h00, 8'h02, 8'h01);
		check({7'h00, (acc_t - we_t) >= `DCP_PREERASE_CYC}, 8'h01);
		check({7'h00, last_pc}, 8'h00);
		wreg(`DCP_A_PRECOMP_START_TRACK, 8'h01);
		sect(8'h06, 8'h00, 8'h01, 8'h02, 8'h00, 8'h02, 8'h01);
		check({7'h00, last_pc}, 8'h01);
		summarize();
	end
endmodule
`default_nettype wire
